/* File: shared/isc_pkg.sv */
// Constants for the interrupt mode and shadow set control block.
// Assumes one 100 MHz clock and a simple strobe register port.
// Operation
// - Accept eight hardware, two software and one timer interrupt source.
// - Support legacy, vectored and external-controller interrupt modes.
// - Vectored-mode presence bit is hardwired and always reads one.
// - Controller-presence bit follows a static input held constant by system logic.
// - Reset leaves the block in legacy mode until software selects another.
// - Shadow set count is a build parameter; highest set number is readable.
// - Highest set field of zero means only the normal register file.
// - Normal register file counts as shadow set zero.
// - Ordinary register references go to the currently selected set.
// - Two privileged accesses reach registers of the previous set.
// - Control register holds current set and previous set fields.
// - Vectored mode takes the entry set from the vector mapping registers.
// - External-controller mode uses the set number the controller supplies.
// - Exceptions and non-vectored interrupts use the exception set field.
// - Unchained entry copies current set to previous, then loads current from mode source.
// - Exception return copies previous set back into current.
// - Vector prefetch starts while the pipeline flushes for an accepted interrupt.
// - Hardware prologue saves the control word on interrupt entry.
// - Hardware epilogue restores the control word on interrupt return.
// - With chaining on and another pending, jump straight to next handler.
// - User, kernel and debug privilege; exceptions enter kernel.
package isc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CFG_WORD3 = 8'h00;
  localparam logic [7:0] ADDR_SHADOW_CTL = 8'h04;
  localparam logic [7:0] ADDR_MAP_LO = 8'h08;
  localparam logic [7:0] ADDR_MAP_HI = 8'h0C;
  localparam logic [7:0] ADDR_INT_CTL = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;
  localparam logic [7:0] ADDR_INT_PEND = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_SAVED = 8'h20;
  localparam logic [7:0] ADDR_COUNT = 8'h24;
  localparam logic [7:0] ADDR_COMPARE = 8'h28;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_VECTORED_BIT = 5;
  localparam int CFG_EXT_BIT = 6;
  localparam int SSC_CUR_LSB = 0;
  localparam int SSC_PRV_LSB = 6;
  localparam int SSC_EXC_LSB = 12;
  localparam int SSC_TOP_LSB = 26;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_IE_BIT = 4;
  localparam int CTL_CHAIN_BIT = 5;
  localparam int CTL_PRO_BIT = 6;
  localparam int CTL_EPI_BIT = 7;
  localparam int SET_W = 4;
  localparam int NSRC = 11;
  localparam int SRC_TIMER = 10;
  // ----------------------------------------
  // Reset values and vector layout
  // ----------------------------------------
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] VEC_BASE = 32'h8000_0000;
  localparam logic [31:0] COMPAT_OFS = 32'h0000_0200;
  localparam logic [31:0] VEC_SPACING = 32'h0000_0020;
  // ----------------------------------------
  // Modes, privilege, states
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_LEGACY = 2'h0, MODE_VECTORED = 2'h1, MODE_EXTERNAL = 2'h2} isc_mode_e;
  typedef enum logic [1:0] {PRIV_USER = 2'h0, PRIV_KERNEL = 2'h1, PRIV_DEBUG = 2'h2} isc_priv_e;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_FLUSH = 3'h2, ST_SERVICE = 3'h4} isc_state_e;
endpackage

/* File: src/isc_top.sv */
// Interrupt mode selection, dispatch and shadow set control.
// Assumes the pipeline signals flushes, exception entry and return with one-cycle pulses.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module isc_top #(
  parameter int NUM_SETS = 16,
  parameter int HW_IRQS = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [HW_IRQS-1:0] hw_irq,
  input wire logic ext_ctrl_present_in,
  input wire logic xic_req,
  input wire logic [3:0] xic_vector,
  input wire logic [3:0] xic_set,
  input wire logic exc_req,
  input wire logic exception_return,
  input wire logic flush_done,
  input wire logic debug_enter,
  input wire logic debug_exit,
  input wire logic prev_set_access,
  input wire logic [31:0] ctrl_word_in,
  output logic flush_req,
  output logic vec_prefetch,
  output logic [31:0] vec_addr,
  output logic entry_commit,
  output logic xic_ack,
  output logic [3:0] gpr_set,
  output logic [3:0] prev_gpr_set,
  output logic prev_access_fault,
  output logic ctrl_restore_valid,
  output logic [31:0] ctrl_restore,
  output logic [1:0] priv_mode
);
  localparam logic [3:0] TOP_SET = 4'(NUM_SETS - 1);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [HW_IRQS-1:0] hw_meta;
  logic [HW_IRQS-1:0] hw_sync;
  logic [8:0] xic_meta;
  logic [8:0] xic_sync;
  logic ext_meta;
  logic ext_sync;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      hw_meta <= '0;
      hw_sync <= '0;
      xic_meta <= '0;
      xic_sync <= '0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else
    begin
      hw_meta <= hw_irq;
      hw_sync <= hw_meta;
      xic_meta <= {xic_req, xic_vector, xic_set};
      xic_sync <= xic_meta;
      ext_meta <= ext_ctrl_present_in;
      ext_sync <= ext_meta;
    end

  wire logic xic_req_s = xic_sync[8];
  wire logic [3:0] xic_vec_s = xic_sync[7:4];
  wire logic [3:0] xic_set_s = xic_sync[3:0];
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [31:0] int_ctl;
  logic [isc_pkg::NSRC-1:0] int_mask;
  logic [1:0] sw_pend;
  logic timer_pend;
  logic [31:0] count;
  logic [31:0] compare;
  logic [63:0] shadow_map;
  logic [3:0] exception_shadow_set;
  logic [3:0] current_shadow_set;
  logic [3:0] previous_shadow_set;
  logic [31:0] saved_ctrl;
  logic [1:0] saved_priv;
  logic chaining;
  isc_pkg::isc_state_e state;
  isc_pkg::isc_priv_e priv;

  wire logic wr_ctl = reg_wr && reg_addr == isc_pkg::ADDR_INT_CTL;
  wire logic wr_ssc = reg_wr && reg_addr == isc_pkg::ADDR_SHADOW_CTL;
  wire logic [1:0] mode = int_ctl[isc_pkg::CTL_MODE_LSB +: 2];
  wire logic ie = int_ctl[isc_pkg::CTL_IE_BIT];
  wire logic chain_en = int_ctl[isc_pkg::CTL_CHAIN_BIT];
  wire logic auto_prologue = int_ctl[isc_pkg::CTL_PRO_BIT];
  wire logic auto_epilogue = int_ctl[isc_pkg::CTL_EPI_BIT];

  // Mode write; external mode only sticks when a controller is present
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      int_ctl <= isc_pkg::CTL_RESET;
    else if (wr_ctl)
    begin
      int_ctl <= {24'h000000, reg_wdata[7:4], 2'h0, reg_wdata[1:0]};
      if (reg_wdata[1:0] == isc_pkg::MODE_EXTERNAL && !ext_sync)
        int_ctl[1:0] <= isc_pkg::MODE_LEGACY;
      else if (reg_wdata[1:0] == 2'h3)
        int_ctl[1:0] <= isc_pkg::MODE_LEGACY;
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      int_mask <= '0;
      shadow_map <= '0;
      exception_shadow_set <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == isc_pkg::ADDR_INT_MASK)
        int_mask <= reg_wdata[isc_pkg::NSRC-1:0];
      else if (reg_addr == isc_pkg::ADDR_MAP_LO)
        shadow_map[31:0] <= reg_wdata;
      else if (reg_addr == isc_pkg::ADDR_MAP_HI)
        shadow_map[63:32] <= reg_wdata;
      else if (wr_ssc)
        exception_shadow_set <= reg_wdata[isc_pkg::SSC_EXC_LSB +: 4] & TOP_SET;
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      sw_pend <= '0;
    else if (reg_wr && reg_addr == isc_pkg::ADDR_INT_PEND)
      sw_pend <= reg_wdata[1:0];

  // Timer: free count, sticky match, cleared by compare write; match wins
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      count <= '0;
      compare <= isc_pkg::COMPARE_RESET;
      timer_pend <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == isc_pkg::ADDR_COUNT)
        count <= reg_wdata;
      else
        count <= count + 32'h0000_0001;
      if (reg_wr && reg_addr == isc_pkg::ADDR_COMPARE)
        compare <= reg_wdata;
      if (count == compare)
        timer_pend <= 1'b1;
      else if (reg_wr && reg_addr == isc_pkg::ADDR_COMPARE)
        timer_pend <= 1'b0;
    end
  // ----------------------------------------
  // Request selection
  // ----------------------------------------
  wire logic [isc_pkg::NSRC-1:0] pending = {timer_pend, hw_sync, sw_pend};
  wire logic [isc_pkg::NSRC-1:0] active = pending & int_mask;
  logic [3:0] top_src;

  always_comb
  begin
    top_src = '0;
    for (int i = 0; i < isc_pkg::NSRC; i++)
      if (active[i])
        top_src = 4'(i);
  end

  logic req_valid;
  logic [3:0] next_set;
  logic [31:0] next_vec;

  always_comb
  begin
    req_valid = 1'b0;
    next_set = exception_shadow_set;
    next_vec = isc_pkg::VEC_BASE + isc_pkg::COMPAT_OFS;
    case (mode)
      isc_pkg::MODE_VECTORED:
      begin
        req_valid = |active;
        next_set = shadow_map[top_src*4 +: 4] & TOP_SET;
        next_vec = isc_pkg::VEC_BASE + isc_pkg::COMPAT_OFS + {28'h0000000, top_src} * isc_pkg::VEC_SPACING;
      end
      isc_pkg::MODE_EXTERNAL:
      begin
        req_valid = xic_req_s && ext_sync;
        next_set = xic_set_s & TOP_SET;
        next_vec = isc_pkg::VEC_BASE + isc_pkg::COMPAT_OFS + {28'h0000000, xic_vec_s} * isc_pkg::VEC_SPACING;
      end
      default:
        req_valid = |active;
    endcase
  end

  wire logic can_take = ie && priv != isc_pkg::PRIV_DEBUG && !exc_req;
  wire logic take_new = state == isc_pkg::ST_IDLE && req_valid && can_take;
  wire logic take_chain = state == isc_pkg::ST_SERVICE && exception_return && chain_en && req_valid && can_take;
  wire logic commit = state == isc_pkg::ST_FLUSH && flush_done;
  // ----------------------------------------
  // Dispatch state machine
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      state <= isc_pkg::ST_IDLE;
    else
      case (state)
        isc_pkg::ST_IDLE:
          if (take_new)
            state <= isc_pkg::ST_FLUSH;
        isc_pkg::ST_FLUSH:
          if (commit)
            state <= isc_pkg::ST_SERVICE;
        isc_pkg::ST_SERVICE:
          if (take_chain)
            state <= isc_pkg::ST_FLUSH;
          else if (exception_return)
            state <= isc_pkg::ST_IDLE;
        default:
          state <= isc_pkg::ST_IDLE;
      endcase

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      chaining <= 1'b0;
    else if (take_chain)
      chaining <= 1'b1;
    else if (take_new)
      chaining <= 1'b0;

  // Vector held from acceptance; prefetch runs during the flush
  logic [3:0] pick_set;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      vec_addr <= isc_pkg::VEC_BASE;
      pick_set <= '0;
      flush_req <= 1'b0;
      vec_prefetch <= 1'b0;
    end
    else
    begin
      if (take_new || take_chain)
      begin
        vec_addr <= next_vec;
        pick_set <= next_set;
      end
      flush_req <= (take_new || take_chain) || (state == isc_pkg::ST_FLUSH && !flush_done);
      vec_prefetch <= (take_new || take_chain) || (state == isc_pkg::ST_FLUSH && !flush_done);
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      entry_commit <= 1'b0;
      xic_ack <= 1'b0;
    end
    else
    begin
      entry_commit <= commit;
      xic_ack <= commit && mode == isc_pkg::MODE_EXTERNAL;
    end
  // ----------------------------------------
  // Shadow set tracking
  // ----------------------------------------
  wire logic exc_entry = exc_req && priv != isc_pkg::PRIV_DEBUG;
  wire logic plain_return = exception_return && !take_chain && state != isc_pkg::ST_FLUSH;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      current_shadow_set <= '0;
      previous_shadow_set <= '0;
    end
    else if (exc_entry)
    begin
      previous_shadow_set <= current_shadow_set;
      current_shadow_set <= exception_shadow_set;
    end
    else if (commit)
    begin
      if (!chaining)
        previous_shadow_set <= current_shadow_set;
      current_shadow_set <= pick_set;
    end
    else if (plain_return)
      current_shadow_set <= previous_shadow_set;
    else if (wr_ssc && priv == isc_pkg::PRIV_KERNEL)
      previous_shadow_set <= reg_wdata[isc_pkg::SSC_PRV_LSB +: 4] & TOP_SET;

  // Register file steering; previous-set access faults only in user mode
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      gpr_set <= '0;
      prev_gpr_set <= '0;
      prev_access_fault <= 1'b0;
    end
    else
    begin
      gpr_set <= current_shadow_set;
      prev_gpr_set <= previous_shadow_set;
      prev_access_fault <= prev_set_access && priv == isc_pkg::PRIV_USER;
    end
  // ----------------------------------------
  // Privilege, prologue and epilogue
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      priv <= isc_pkg::PRIV_KERNEL;
      saved_priv <= isc_pkg::PRIV_KERNEL;
    end
    else if (debug_enter)
      priv <= isc_pkg::PRIV_DEBUG;
    else if (debug_exit && priv == isc_pkg::PRIV_DEBUG)
      priv <= isc_pkg::isc_priv_e'(saved_priv);
    else if (exc_entry || (commit && !chaining))
    begin
      saved_priv <= priv;
      priv <= isc_pkg::PRIV_KERNEL;
    end
    else if (plain_return && priv == isc_pkg::PRIV_KERNEL)
      priv <= isc_pkg::isc_priv_e'(saved_priv);
    else if (reg_wr && reg_addr == isc_pkg::ADDR_STATUS && priv == isc_pkg::PRIV_KERNEL)
      priv <= isc_pkg::PRIV_USER;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      saved_ctrl <= '0;
    else if (commit && !chaining && auto_prologue)
      saved_ctrl <= ctrl_word_in;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ctrl_restore_valid <= 1'b0;
      ctrl_restore <= '0;
    end
    else
    begin
      ctrl_restore_valid <= state == isc_pkg::ST_SERVICE && plain_return && auto_epilogue;
      ctrl_restore <= saved_ctrl;
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      priv_mode <= isc_pkg::PRIV_KERNEL;
    else
      priv_mode <= priv;
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      if (reg_addr == isc_pkg::ADDR_CFG_WORD3)
      begin
        reg_rdata <= '0;
        reg_rdata[isc_pkg::CFG_VECTORED_BIT] <= 1'b1;
        reg_rdata[isc_pkg::CFG_EXT_BIT] <= ext_sync;
      end
      else if (reg_addr == isc_pkg::ADDR_SHADOW_CTL)
      begin
        reg_rdata <= '0;
        reg_rdata[isc_pkg::SSC_TOP_LSB +: 4] <= TOP_SET;
        reg_rdata[isc_pkg::SSC_EXC_LSB +: 4] <= exception_shadow_set;
        reg_rdata[isc_pkg::SSC_PRV_LSB +: 4] <= previous_shadow_set;
        reg_rdata[isc_pkg::SSC_CUR_LSB +: 4] <= current_shadow_set;
      end
      else if (reg_addr == isc_pkg::ADDR_MAP_LO)
        reg_rdata <= shadow_map[31:0];
      else if (reg_addr == isc_pkg::ADDR_MAP_HI)
        reg_rdata <= shadow_map[63:32];
      else if (reg_addr == isc_pkg::ADDR_INT_CTL)
        reg_rdata <= int_ctl;
      else if (reg_addr == isc_pkg::ADDR_INT_MASK)
        reg_rdata <= {21'h000000, int_mask};
      else if (reg_addr == isc_pkg::ADDR_INT_PEND)
        reg_rdata <= {21'h000000, pending};
      else if (reg_addr == isc_pkg::ADDR_STATUS)
        reg_rdata <= {24'h000000, 3'(state), chaining, 2'h0, priv};
      else if (reg_addr == isc_pkg::ADDR_SAVED)
        reg_rdata <= saved_ctrl;
      else if (reg_addr == isc_pkg::ADDR_COUNT)
        reg_rdata <= count;
      else if (reg_addr == isc_pkg::ADDR_COMPARE)
        reg_rdata <= compare;
      else
        reg_rdata <= '0;
    end

endmodule // isc_top

/* File: tb/isc_irq_model.sv */
// Model of the interrupt sources, the external controller and the pipeline flush.
// Assumes the testbench commands it at rising edges of the one core clock.
`timescale 1ns/1ns
module isc_irq_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] hw_lvl,
  input wire logic xic_go,
  input wire logic [3:0] xic_vec_i,
  input wire logic [3:0] xic_set_i,
  input wire logic [3:0] flush_lat,
  input wire logic flush_req,
  input wire logic xic_ack,
  output logic [7:0] hw_irq,
  output logic xic_req,
  output logic [3:0] xic_vector,
  output logic [3:0] xic_set,
  output logic flush_done
);
  logic [3:0] cnt;
  logic sent;

  // ----------------------------------------
  // Sources and controller
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      hw_irq <= 8'h00;
    else
      hw_irq <= hw_lvl;

  // Request held until acknowledged, then fields go stale
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      xic_req <= 1'b0;
      xic_vector <= 4'h0;
      xic_set <= 4'h0;
    end
    else if (xic_go)
    begin
      xic_req <= 1'b1;
      xic_vector <= xic_vec_i;
      xic_set <= xic_set_i;
    end
    else if (xic_ack)
    begin
      xic_req <= 1'b0;
      xic_vector <= ~xic_vector;
      xic_set <= ~xic_set;
    end

  // ----------------------------------------
  // Pipeline flush, one done pulse per request
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt <= 4'h0;
      sent <= 1'b0;
      flush_done <= 1'b0;
    end
    else
    begin
      flush_done <= 1'b0;
      if (!flush_req)
      begin
        cnt <= 4'h0;
        sent <= 1'b0;
      end
      else if (!sent && cnt == flush_lat)
      begin
        flush_done <= 1'b1;
        sent <= 1'b1;
      end
      else if (!sent)
        cnt <= cnt + 4'h1;
    end
endmodule // isc_irq_model

/* File: tb/isc_top_asserts.sv */
// Concurrent checks on the ports of the interrupt and shadow set block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ns
module isc_top_asserts #(
  parameter int NUM_SETS = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic ext_ctrl_present_in,
  input wire logic exc_req,
  input wire logic exception_return,
  input wire logic flush_done,
  input wire logic debug_enter,
  input wire logic prev_set_access,
  input wire logic flush_req,
  input wire logic vec_prefetch,
  input wire logic [31:0] vec_addr,
  input wire logic entry_commit,
  input wire logic xic_ack,
  input wire logic [3:0] gpr_set,
  input wire logic [3:0] prev_gpr_set,
  input wire logic prev_access_fault,
  input wire logic ctrl_restore_valid,
  input wire logic [1:0] priv_mode
);
  localparam logic [3:0] SET_MAX = 4'(NUM_SETS - 1);

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Entry, return, privilege, set bound and configuration read
  // ----------------------------------------
  prefetch_flush_a: assert property (vec_prefetch == flush_req)
    else $error("prefetch differs from flush request");
  flush_hold_a: assert property (flush_req && !flush_done |=> flush_req)
    else $error("flush request dropped early");
  vec_stable_a: assert property (flush_req && $past(flush_req) |-> $stable(vec_addr))
    else $error("vector address moved during flush");
  commit_time_a: assert property (flush_req && flush_done |=> entry_commit && !flush_req)
    else $error("entry commit not one cycle after flush done");
  commit_kernel_a: assert property (entry_commit && !$past(debug_enter) |=> priv_mode == 2'h1)
    else $error("entry did not reach kernel mode");
  ret_restore_a: assert property (exception_return && !exc_req && !reg_wr ##1 !flush_req
    |-> ##1 gpr_set == $past(prev_gpr_set, 2)) else $error("return did not restore previous set");
  ack_commit_a: assert property (xic_ack |-> entry_commit)
    else $error("controller acknowledge outside commit");
  fault_user_a: assert property (prev_access_fault == ($past(prev_set_access) && priv_mode == 2'h0))
    else $error("previous set access fault wrong");
  debug_priv_a: assert property (debug_enter |-> ##2 priv_mode == 2'h2)
    else $error("debug entry not seen in privilege");
  restore_ret_a: assert property (ctrl_restore_valid |-> $past(exception_return))
    else $error("control restore without return");
  set_bound_a: assert property (gpr_set <= SET_MAX && prev_gpr_set <= SET_MAX)
    else $error("shadow set above highest set");
  config_read_a: assert property (reg_rd && reg_addr == isc_pkg::ADDR_CFG_WORD3
    |=> reg_rdata[6:5] == {ext_ctrl_present_in, 1'b1}) else $error("configuration bits wrong");
endmodule // isc_top_asserts

bind isc_top isc_top_asserts #(.NUM_SETS(NUM_SETS)) chk_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_ctrl_present_in(ext_ctrl_present_in),
  .exc_req(exc_req), .exception_return(exception_return), .flush_done(flush_done), .debug_enter(debug_enter),
  .prev_set_access(prev_set_access), .flush_req(flush_req), .vec_prefetch(vec_prefetch), .vec_addr(vec_addr),
  .entry_commit(entry_commit), .xic_ack(xic_ack), .gpr_set(gpr_set), .prev_gpr_set(prev_gpr_set),
  .prev_access_fault(prev_access_fault), .ctrl_restore_valid(ctrl_restore_valid), .priv_mode(priv_mode));

/* File: tb/testbench.sv */
// Self-checking bench for the interrupt mode and shadow set block.
// Assumes the flush and controller model and the bound port checker.
`timescale 1ns/1ns
module testbench;
  localparam int NSETS = 8;
  localparam logic [31:0] TOP_F = 32'(NSETS - 1) << isc_pkg::SSC_TOP_LSB;
  localparam logic [31:0] SC = TOP_F | 32'h0000_3000;
  localparam logic [31:0] VB = isc_pkg::VEC_BASE + isc_pkg::COMPAT_OFS;
  logic clk;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] hw_lvl = 8'h00;
  logic xic_go = 1'b0;
  logic [3:0] xic_vec_i = 4'h0;
  logic [3:0] xic_set_i = 4'h0;
  logic [3:0] flush_lat = 4'h2;
  logic ext_ctrl_present_in = 1'b1;
  logic exc_req = 1'b0;
  logic exception_return = 1'b0;
  logic debug_enter = 1'b0;
  logic debug_exit = 1'b0;
  logic prev_set_access = 1'b0;
  logic [31:0] ctrl_word_in = 32'h0;
  logic [31:0] reg_rdata, vec_addr, ctrl_restore;
  logic [7:0] hw_irq;
  logic [3:0] xic_vector, xic_set, gpr_set, prev_gpr_set;
  logic [1:0] priv_mode;
  logic xic_req, flush_done, flush_req, vec_prefetch, entry_commit, xic_ack, prev_access_fault, ctrl_restore_valid;
  int err_total = 0;
  int n_tests = 0;

  isc_top #(.NUM_SETS(NSETS), .HW_IRQS(8)) uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_irq(hw_irq),
    .ext_ctrl_present_in(ext_ctrl_present_in), .xic_req(xic_req), .xic_vector(xic_vector), .xic_set(xic_set),
    .exc_req(exc_req), .exception_return(exception_return), .flush_done(flush_done), .debug_enter(debug_enter),
    .debug_exit(debug_exit), .prev_set_access(prev_set_access), .ctrl_word_in(ctrl_word_in),
    .flush_req(flush_req), .vec_prefetch(vec_prefetch), .vec_addr(vec_addr), .entry_commit(entry_commit),
    .xic_ack(xic_ack), .gpr_set(gpr_set), .prev_gpr_set(prev_gpr_set), .prev_access_fault(prev_access_fault),
    .ctrl_restore_valid(ctrl_restore_valid), .ctrl_restore(ctrl_restore), .priv_mode(priv_mode));

  isc_irq_model irq_src (.clk(clk), .rst_b(rst_b), .hw_lvl(hw_lvl), .xic_go(xic_go), .xic_vec_i(xic_vec_i),
    .xic_set_i(xic_set_i), .flush_lat(flush_lat), .flush_req(flush_req), .xic_ack(xic_ack), .hw_irq(hw_irq),
    .xic_req(xic_req), .xic_vector(xic_vector), .xic_set(xic_set), .flush_done(flush_done));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Waits for flush request (0) or entry commit (1)
  task automatic wait_ev(input int k);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk);
      #1;
      if (((k == 0) ? flush_req : entry_commit) === 1'b1)
        return;
    end
    err_total++;
    end_of_test();
  endtask

  task automatic ret;
    @(posedge clk);
    exception_return <= 1'b1;
    @(posedge clk);
    exception_return <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(32'(priv_mode), 32'h1);
    chk(vec_addr, isc_pkg::VEC_BASE);
    rdc(isc_pkg::ADDR_CFG_WORD3, 32'h60);
    rdc(isc_pkg::ADDR_SHADOW_CTL, TOP_F);
    rdc(isc_pkg::ADDR_INT_CTL, 32'h0);
    rdc(8'hFC, 32'h0);
    wr(isc_pkg::ADDR_INT_CTL, 32'h3);
    rdc(isc_pkg::ADDR_INT_CTL, 32'h0);
  endtask

  task automatic t_legacy;
    wr(isc_pkg::ADDR_SHADOW_CTL, 32'h3000);
    wr(isc_pkg::ADDR_INT_MASK, 32'h7FF);
    wr(isc_pkg::ADDR_INT_CTL, 32'h10);
    hw_lvl <= 8'h01;
    wait_ev(0);
    hw_lvl <= 8'h00;
    chk(vec_addr, VB);
    wait_ev(1);
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC | 32'h3);
    chk(32'(gpr_set), 32'h3);
    ret();
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC);
  endtask

  task automatic t_vectored;
    wr(isc_pkg::ADDR_MAP_LO, 32'h0002_0000);
    wr(isc_pkg::ADDR_MAP_HI, 32'h0000_0050);
    wr(isc_pkg::ADDR_INT_CTL, 32'hF1);
    ctrl_word_in <= 32'hA5A5_0F0F;
    hw_lvl <= 8'h84;
    flush_lat <= 4'h9;
    wait_ev(0);
    chk(vec_addr, VB + isc_pkg::VEC_SPACING * 32'd9);
    wait_ev(1);
    hw_lvl <= 8'h04;
    ctrl_word_in <= 32'h0;
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC | 32'h5);
    repeat (3) @(posedge clk);
    ret();
    chk({30'h0, flush_req, ctrl_restore_valid}, 32'h2);
    chk(vec_addr, VB + isc_pkg::VEC_SPACING * 32'd4);
    wait_ev(1);
    hw_lvl <= 8'h00;
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC | 32'h2);
    repeat (3) @(posedge clk);
    ret();
    chk({ctrl_restore_valid, ctrl_restore[30:0]}, 32'hA5A5_0F0F);
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC);
  endtask

  task automatic t_external;
    wr(isc_pkg::ADDR_INT_CTL, 32'h12);
    xic_go <= 1'b1;
    xic_vec_i <= 4'h6;
    xic_set_i <= 4'h4;
    flush_lat <= 4'h0;
    @(posedge clk);
    xic_go <= 1'b0;
    wait_ev(1);
    chk(32'(xic_ack), 32'h1);
    chk(vec_addr, VB + isc_pkg::VEC_SPACING * 32'd6);
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC | 32'h4);
    ret();
    rdc(isc_pkg::ADDR_SHADOW_CTL, SC);
  endtask

  task automatic t_misc;
    prev_set_access <= 1'b1;
    @(posedge clk);
    prev_set_access <= 1'b0;
    #1;
    chk(32'(prev_access_fault), 32'h0);
    wr(isc_pkg::ADDR_STATUS, 32'h0);
    prev_set_access <= 1'b1;
    @(posedge clk);
    prev_set_access <= 1'b0;
    #1;
    chk({30'h0, prev_access_fault, priv_mode == 2'h0}, 32'h3);
    debug_enter <= 1'b1;
    @(posedge clk);
    debug_enter <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(priv_mode), 32'h2);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_legacy();
    t_vectored();
    t_external();
    @(posedge clk);
    t_misc();
    end_of_test();
  end
endmodule // testbench
